// file: pkg/uv_pkg.sv
// Purpose: shared constants and carriers for the power-state manager
// Assumes: 100 MHz clock, classic wishbone register access
// Notes: thresholds in 100 mV steps, times in 100 ms steps, run-on in minutes
package uv_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_MIN = 600;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_THRESH = 8'h00;
  localparam logic [7:0] ADDR_TIMES = 8'h04;
  localparam logic [7:0] ADDR_RUNON = 8'h08;
  localparam logic [7:0] ADDR_AWAKE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_VOLT = 8'h14;

  // ----------------------------------------------------------------
  // field widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned VW = 8;
  localparam int unsigned TW = 8;
  localparam int unsigned RW = 8;
  localparam int unsigned SELW = 5;
  localparam logic [VW-1:0] ACT_THR_RST = 8'h6e;
  localparam logic [VW-1:0] DEACT_THR_RST = 8'h78;
  localparam logic [TW-1:0] TIME_RST = 8'h0a;
  localparam logic [RW-1:0] RUNON_RST = 8'h05;
  localparam logic [1:0] AWAKE_ENABLE_CODE = 2'h1;

  // undervoltage modes
  typedef enum logic [1:0] {
    UV_NORMAL,
    UV_DETECTED,
    UV_TERMINATE
  } uv_mode_e;

  // undervoltage configuration
  typedef struct packed {
    logic [VW-1:0] act_thr;
    logic [VW-1:0] deact_thr;
    logic [TW-1:0] act_time;
    logic [TW-1:0] term_time;
    logic [TW-1:0] deact_time;
  } uv_cfg_s;

  // undervoltage status
  typedef struct packed {
    uv_mode_e mode;
    logic detected;
    logic terminate;
  } uv_stat_s;

endpackage : uv_pkg

// file: design/uv_monitor.sv
// Purpose: three-mode undervoltage state machine with dwell timers
// Assumes: voltage words already synchronised, tick is a one-cycle 100 ms pulse
// Notes: a zero dwell time gives an immediate transition
`timescale 1ns/1ps
module uv_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // inputs
  input wire logic tick_i,
  input wire logic [uv_pkg::VW-1:0] volt_i,
  input wire uv_pkg::uv_cfg_s cfg_i,
  // status
  output uv_pkg::uv_stat_s stat_o
);
  import uv_pkg::*;

  typedef struct packed {
    uv_mode_e mode;
    logic [TW-1:0] cnt;
  } st_s;

  st_s st_ff;
  st_s nxt_st;
  logic low;
  logic high;

  // threshold compare
  assign low = volt_i < cfg_i.act_thr;
  assign high = volt_i > cfg_i.deact_thr;

  // mode sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.mode)
      UV_NORMAL: begin
        if (!low) begin
          nxt_st.cnt = '0;
        end else if (st_ff.cnt >= cfg_i.act_time) begin
          nxt_st.mode = UV_DETECTED;
          nxt_st.cnt = '0;
        end else if (tick_i) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      UV_DETECTED: begin
        if (high && st_ff.cnt >= cfg_i.deact_time) begin
          nxt_st.mode = UV_NORMAL;
          nxt_st.cnt = '0;
        end else if (!high && st_ff.cnt >= cfg_i.term_time) begin
          nxt_st.mode = UV_TERMINATE;
          nxt_st.cnt = '0;
        end else if (tick_i) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      UV_TERMINATE: begin
        if (!high) begin
          nxt_st.cnt = '0;
        end else if (st_ff.cnt >= cfg_i.deact_time) begin
          nxt_st.mode = UV_NORMAL;
          nxt_st.cnt = '0;
        end else if (tick_i) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      default: begin
        nxt_st.mode = UV_NORMAL;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{mode: UV_NORMAL, cnt: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // status view
  // one driver for the whole status word
  assign stat_o = '{mode: st_ff.mode,
                    detected: st_ff.mode != UV_NORMAL,
                    terminate: st_ff.mode == UV_TERMINATE};

endmodule : uv_monitor

// file: design/runon_timer.sv
// Purpose: run-on countdown in minutes
// Assumes: lock and unlock are one-cycle pulses, tick is 100 ms
// Notes: unlock wins over lock in the same cycle
`timescale 1ns/1ps
module runon_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic tick_i,
  input wire logic lock_i,
  input wire logic unlock_i,
  input wire logic [uv_pkg::RW-1:0] minutes_i,
  // status
  output logic running_o,
  output logic expired_o,
  output logic [uv_pkg::RW-1:0] remain_o
);
  import uv_pkg::*;

  typedef struct packed {
    logic run;
    logic [RW-1:0] mins;
    logic [9:0] sub;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // countdown
  always_comb begin
    nxt_st = st_ff;
    if (unlock_i) begin
      nxt_st.run = 1'b0;
      nxt_st.mins = minutes_i;
      nxt_st.sub = '0;
    end else if (lock_i && !st_ff.run) begin
      nxt_st.run = 1'b1;
      nxt_st.sub = '0;
    end else if (st_ff.run && st_ff.mins != '0 && tick_i) begin
      if (st_ff.sub == 10'(TICKS_PER_MIN - 1)) begin
        nxt_st.sub = '0;
        nxt_st.mins = st_ff.mins - 1'b1;
      end else begin
        nxt_st.sub = st_ff.sub + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{run: 1'b0, mins: RUNON_RST, sub: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign running_o = st_ff.run && st_ff.mins != '0;
  assign expired_o = st_ff.run && st_ff.mins == '0;
  assign remain_o = st_ff.mins;

endmodule : runon_timer

// file: design/undervoltage_runon_keepawake.sv
// Purpose: power-state manager: undervoltage modes, run-on, stay-awake
// Assumes: supplies, lock events and pool bits arrive asynchronously
// Notes: registers over classic wishbone, 32-bit words
`timescale 1ns/1ps
module undervoltage_runon_keepawake #(
  parameter int unsigned TICK_CYCLES = uv_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // supply measurements, 100 mV units
  input wire logic [uv_pkg::VW-1:0] supply_a_i,
  input wire logic [uv_pkg::VW-1:0] supply_b_i,
  input wire logic hw_uv_i,
  // locking events and signal pool
  input wire logic lock_i,
  input wire logic unlock_i,
  input wire logic [(1 << uv_pkg::SELW)-1:0] pool_i,
  // function requests and results
  input wire logic [7:0] func_req_i,
  output logic [7:0] func_en_o,
  output logic undervoltage_detected_flag_o,
  output logic undervoltage_terminate_flag_o,
  output logic internal_keep_awake_o,
  output logic sleep_ok_o
);
  import uv_pkg::*;

  localparam int unsigned PW = 1 << SELW;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    uv_cfg_s cfg;
    logic [RW-1:0] runon_min;
    logic [1:0] awake_en;
    logic [SELW-1:0] awake_sel;
    logic [7:0] vdep_mask;
    logic [31:0] rdata;
    logic ack;
    logic [31:0] tick_cnt;
    logic tick;
    logic [VW-1:0] volt;
    logic lock_q;
    logic unlock_q;
    logic [7:0] fen;
    logic det;
    logic term;
    logic keep;
    logic sleep;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // synchroniser stages
  logic [VW-1:0] sa_m_ff, sa_s_ff, sb_m_ff, sb_s_ff;
  logic [2:0] ev_m_ff, ev_s_ff, ev_d_ff;
  logic [PW-1:0] pool_m_ff, pool_s_ff;

  uv_stat_s uv_stat;
  logic ro_running;
  logic ro_expired;
  logic [RW-1:0] ro_remain;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sa_m_ff <= '0;
      sa_s_ff <= '0;
      sb_m_ff <= '0;
      sb_s_ff <= '0;
      ev_m_ff <= '0;
      ev_s_ff <= '0;
      ev_d_ff <= '0;
      pool_m_ff <= '0;
      pool_s_ff <= '0;
    end else begin
      sa_m_ff <= supply_a_i;
      sa_s_ff <= sa_m_ff;
      sb_m_ff <= supply_b_i;
      sb_s_ff <= sb_m_ff;
      ev_m_ff <= {hw_uv_i, unlock_i, lock_i};
      ev_s_ff <= ev_m_ff;
      ev_d_ff <= ev_s_ff;
      pool_m_ff <= pool_i;
      pool_s_ff <= pool_m_ff;
    end
  end

  // write one byte lane set into a narrow field
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  uv_monitor u_uv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(st_ff.tick),
    .volt_i(st_ff.volt),
    .cfg_i(st_ff.cfg),
    .stat_o(uv_stat)
  );

  runon_timer u_runon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(st_ff.tick),
    .lock_i(st_ff.lock_q),
    .unlock_i(st_ff.unlock_q),
    .minutes_i(st_ff.runon_min),
    .running_o(ro_running),
    .expired_o(ro_expired),
    .remain_o(ro_remain)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic hit;
    w = '0;
    hit = 1'b0;
    nxt_st = st_ff;
    // 100 ms time base
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt >= TICK_CYCLES - 1) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
    end
    // higher of the two supplies
    nxt_st.volt = (sa_s_ff > sb_s_ff) ? sa_s_ff : sb_s_ff;
    // lock/unlock edges
    nxt_st.lock_q = ev_s_ff[0] && !ev_d_ff[0];
    nxt_st.unlock_q = ev_s_ff[1] && !ev_d_ff[1];
    // gate voltage-dependent functions on termination only
    for (int i = 0; i < 8; i++) begin
      nxt_st.fen[i] = func_req_i[i] && !(st_ff.vdep_mask[i] && uv_stat.terminate);
    end
    nxt_st.det = uv_stat.detected;
    nxt_st.term = uv_stat.terminate || ev_s_ff[2];
    // keep-awake from enable code and chosen pool bit
    nxt_st.keep = (st_ff.awake_en == AWAKE_ENABLE_CODE)
                  && pool_s_ff[st_ff.awake_sel];
    nxt_st.sleep = ro_expired && !st_ff.keep;
    // wishbone: ack one cycle, drops after
    nxt_st.ack = cyc_i && stb_i && !st_ff.ack;
    if (cyc_i && stb_i && !st_ff.ack) begin
      hit = 1'b1;
      if (adr_i == ADDR_THRESH) begin
        w = {16'h0, st_ff.cfg.deact_thr, st_ff.cfg.act_thr};
      end else if (adr_i == ADDR_TIMES) begin
        w = {8'h0, st_ff.cfg.deact_time, st_ff.cfg.term_time, st_ff.cfg.act_time};
      end else if (adr_i == ADDR_RUNON) begin
        w = {24'h0, st_ff.runon_min};
      end else if (adr_i == ADDR_AWAKE) begin
        w = {16'h0, st_ff.vdep_mask, 1'b0, st_ff.awake_sel, st_ff.awake_en};
      end else if (adr_i == ADDR_STATUS) begin
        w = {16'h0, ro_remain, 1'b0, st_ff.sleep, st_ff.keep, ro_running,
             st_ff.term, st_ff.det, uv_stat.mode};
      end else if (adr_i == ADDR_VOLT) begin
        w = {24'h0, st_ff.volt};
      end else begin
        hit = 1'b0;
      end
      nxt_st.rdata = we_i ? 32'h0 : w;
      if (we_i && hit) begin
        w = merge(w, dat_i, sel_i);
        if (adr_i == ADDR_THRESH) begin
          nxt_st.cfg.act_thr = w[7:0];
          nxt_st.cfg.deact_thr = w[15:8];
        end else if (adr_i == ADDR_TIMES) begin
          nxt_st.cfg.act_time = w[7:0];
          nxt_st.cfg.term_time = w[15:8];
          nxt_st.cfg.deact_time = w[23:16];
        end else if (adr_i == ADDR_RUNON) begin
          nxt_st.runon_min = w[7:0];
        end else if (adr_i == ADDR_AWAKE) begin
          nxt_st.awake_en = w[1:0];
          nxt_st.awake_sel = w[6:2];
          nxt_st.vdep_mask = w[15:8];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.cfg <= '{act_thr: ACT_THR_RST, deact_thr: DEACT_THR_RST,
                     act_time: TIME_RST, term_time: TIME_RST, deact_time: TIME_RST};
      st_ff.runon_min <= RUNON_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign dat_o = st_ff.rdata;
  assign ack_o = st_ff.ack;
  assign func_en_o = st_ff.fen;
  assign undervoltage_detected_flag_o = st_ff.det;
  assign undervoltage_terminate_flag_o = st_ff.term;
  assign internal_keep_awake_o = st_ff.keep;
  assign sleep_ok_o = st_ff.sleep;

endmodule : undervoltage_runon_keepawake

// file: verification/uv_partner.sv
// Purpose: far-side model: supply monitor and central locking events
// Assumes: signals change by non-blocking assignment after a rising edge
// Notes: lock and unlock are level pulses, the rising edge is the event
`timescale 1ns/1ps
module uv_partner (
  // clock
  input wire logic clk_i,
  // supplies and locking
  output logic [7:0] supply_a_o,
  output logic [7:0] supply_b_o,
  output logic hw_uv_o,
  output logic lock_o,
  output logic unlock_o
);
  // idle: both supplies healthy, no events
  initial begin
    {supply_a_o, supply_b_o, hw_uv_o, lock_o, unlock_o} = {8'h80, 8'h80, 3'b000};
  end
  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  task automatic set_supply(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    {supply_a_o, supply_b_o} <= {a, b};
  endtask : set_supply
  task automatic set_hw(input logic v);
    @(posedge clk_i);
    hw_uv_o <= v;
  endtask : set_hw
  // remote key press, held a few cycles then released
  task automatic key(input logic unlock);
    @(posedge clk_i);
    if (unlock) unlock_o <= 1'b1;
    else lock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    {lock_o, unlock_o} <= 2'b00;
  endtask : key
endmodule : uv_partner

// file: verification/uvrk_properties.sv
// Purpose: port-level checks of the power-state manager
// Assumes: bound to the top module, single clock domain
// Notes: bench scenarios reach every antecedent
`timescale 1ns/1ps
module uvrk_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // pins
  input wire logic hw_uv_i,
  input wire logic unlock_i,
  input wire logic [7:0] func_req_i,
  input wire logic [7:0] func_en_o,
  input wire logic undervoltage_detected_flag_o,
  input wire logic undervoltage_terminate_flag_o,
  input wire logic internal_keep_awake_o,
  input wire logic sleep_ok_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ##1 ack_o ##1 !ack_o;
  endsequence
  property p_bus_answer;
    s_take |-> s_answer;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  property p_wr_zero;
    ack_o && $past(we_i) |-> dat_o == 32'h0;
  endproperty
  // no undervoltage for three cycles: requests pass untouched
  property p_func_pass;
    !undervoltage_detected_flag_o && !$past(undervoltage_detected_flag_o)
      && !$past(undervoltage_detected_flag_o, 2) |-> func_en_o == $past(func_req_i);
  endproperty
  property p_keep_blocks;
    internal_keep_awake_o && $past(internal_keep_awake_o) |-> !sleep_ok_o;
  endproperty
  property p_hw_uv;
    hw_uv_i [*4] |=> undervoltage_terminate_flag_o;
  endproperty
  property p_unlock_stop;
    $rose(unlock_i) |-> ##[1:8] !sleep_ok_o;
  endproperty
  property p_reset_quiet;
    $fell(rst_i) |-> !ack_o && !sleep_ok_o && func_en_o == 8'h00;
  endproperty
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_wr_zero: assert property (p_wr_zero) else $error("write data not zero");
  a_func_pass: assert property (p_func_pass) else $error("function gated");
  a_keep_blocks: assert property (p_keep_blocks) else $error("sleep while awake");
  a_hw_uv: assert property (p_hw_uv) else $error("hardware uv lost");
  a_unlock_stop: assert property (p_unlock_stop) else $error("sleep after unlock");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
endmodule : uvrk_properties

// file: verification/tb_undervoltage_runon_keepawake.sv
// Purpose: self-checking bench of the power-state manager
// Assumes: tick shortened to 10 cycles, run-on set to one minute
// Notes: bus master is classic wishbone, one request at a time
`timescale 1ns/1ps
module tb_undervoltage_runon_keepawake;
  import uv_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, hw, lk, ulk, det, term, keep, slp;
  logic [7:0] adr_i = 8'h00, func_req_i = 8'h00, func_en_o, sa, sb;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, pool_i = 32'h0, dat_o, q;
  int fail_count = 0, check_count = 0;
  always #5 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  undervoltage_runon_keepawake #(.TICK_CYCLES(10)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .supply_a_i(sa), .supply_b_i(sb),
    .hw_uv_i(hw), .lock_i(lk), .unlock_i(ulk), .pool_i, .func_req_i, .func_en_o,
    .undervoltage_detected_flag_o(det), .undervoltage_terminate_flag_o(term),
    .internal_keep_awake_o(keep), .sleep_ok_o(slp));
  uv_partner P (.clk_i, .supply_a_o(sa), .supply_b_o(sb), .hw_uv_o(hw), .lock_o(lk),
    .unlock_o(ulk));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // flags as {detected, terminate, keep-awake, sleep ok}
  task automatic fl(input string nm, input logic [3:0] e);
    chk(nm, {28'h0, det, term, keep, slp}, {28'h0, e});
  endtask : fl
  // one classic cycle: hold until ack sampled high, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 20) begin
      chk("ack timeout", 32'h0, 32'h1);
      test_done();
    end
  endtask : bus
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    bus(0, ADDR_THRESH, 0);
    chk("thresh", q, {16'h0, DEACT_THR_RST, ACT_THR_RST});
    // low lane only: the upper byte must be left alone
    sel_i <= 4'h1;
    bus(1, ADDR_THRESH, {16'h0, 8'hff, ACT_THR_RST});
    sel_i <= 4'hf;
    bus(0, ADDR_THRESH, 0);
    chk("lane merge", q, {16'h0, DEACT_THR_RST, ACT_THR_RST});
    bus(0, ADDR_TIMES, 0);
    chk("times", q, {8'h0, TIME_RST, TIME_RST, TIME_RST});
    bus(0, ADDR_RUNON, 0);
    chk("runon", q, {24'h0, RUNON_RST});
    bus(1, 8'h18, 32'hffffffff);
    bus(0, 8'h18, 0);
    chk("unmapped", q, 32'h0);
    bus(0, ADDR_STATUS, 0);
    chk("status", {25'h0, q[6:0]}, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_uv();
    bus(1, ADDR_TIMES, 32'h00030502);
    bus(1, ADDR_AWAKE, 32'h00000f00);
    func_req_i <= 8'hff;
    P.set_supply(8'h50, 8'h82);
    wt(100);
    fl("one supply failed", 4'h0);
    bus(0, ADDR_VOLT, 0);
    chk("volt", q, 32'h82);
    P.set_supply(8'h64, 8'h50);
    wt(5);
    fl("dwell", 4'h0);
    wt(40);
    fl("detected", 4'h8);
    chk("func det", func_en_o, 8'hff);
    wt(70);
    fl("terminate", 4'hc);
    chk("func term", func_en_o, 8'hf0);
    bus(0, ADDR_STATUS, 0);
    chk("mode", q[3:0], 4'he);
    P.set_supply(8'h7f, 8'h79);
    wt(60);
    fl("recovered", 4'h0);
    bus(1, ADDR_TIMES, 32'h00030002);
    P.set_supply(8'h60, 8'h60);
    wt(45);
    fl("zero dwell", 4'hc);
    P.set_supply(8'h82, 8'h82);
    wt(60);
    P.set_hw(1'b1);
    wt(6);
    fl("hw uv", 4'h4);
    P.set_hw(1'b0);
    wt(6);
    fl("hw uv gone", 4'h0);
    $display("test uv done");
  endtask : t_uv
  task automatic t_runon();
    bus(1, ADDR_RUNON, 32'h1);
    // counter takes the programmed minutes only on unlock
    P.key(1'b1);
    P.key(1'b0);
    wt(100);
    bus(0, ADDR_STATUS, 0);
    chk("running", q[4], 1'b1);
    chk("func runon", func_en_o, 8'hff);
    wt(5800);
    fl("not yet", 4'h0);
    wt(300);
    fl("expired", 4'h1);
    pool_i <= 32'h8;
    bus(1, ADDR_AWAKE, 32'h00000f0e);
    wt(8);
    fl("enable 10", 4'h1);
    bus(1, ADDR_AWAKE, 32'h00000f0d);
    wt(8);
    fl("awake", 4'h2);
    pool_i <= 32'hfffffff7;
    wt(8);
    fl("other bit", 4'h1);
    P.key(1'b1);
    wt(10);
    bus(0, ADDR_STATUS, 0);
    chk("reload", {q[15:8], q[6], q[4]}, 10'h004);
    $display("test runon done");
  endtask : t_runon
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    wt(6);
    rst_i <= 1'b0;
    t_regs();
    t_uv();
    t_runon();
    test_done();
  end
endmodule : tb_undervoltage_runon_keepawake
// checker beside the top module
bind undervoltage_runon_keepawake uvrk_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .ack_o, .dat_o, .hw_uv_i, .unlock_i, .func_req_i, .func_en_o,
  .undervoltage_detected_flag_o, .undervoltage_terminate_flag_o, .internal_keep_awake_o,
  .sleep_ok_o);
